// ==== verilog/arseq_pkg.sv ====
// package for the asynchronous reset sequencer: types and timing constants
package arseq_pkg;

    // =========================================================================
    // clock and timing
    localparam int unsigned CLK_PERIOD_PS = 40000;
    localparam int unsigned SPIKE_MAX_PS = 50000;
    // spikes strictly shorter than 50 ns are rejected; round up, at least one cycle
    localparam int unsigned SPIKE_CYC_RAW = (SPIKE_MAX_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SPIKE_CYC = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;
    localparam int unsigned FLASH_INIT_US = 1000;
    // longest time: round down
    localparam int unsigned FLASH_INIT_CYC_DEF = (FLASH_INIT_US * 1000000) / CLK_PERIOD_PS;
    // one half_cpu_period is half a cpu clock; exit delay 3..8 units, counted in whole clocks
    localparam int unsigned HALF_PER_CLK = 2;
    localparam int unsigned EXIT_HALF_MIN = 3;
    localparam int unsigned EXIT_HALF_MAX = 8;
    localparam int unsigned EXIT_CYC_MIN = (EXIT_HALF_MIN + HALF_PER_CLK - 1) / HALF_PER_CLK;
    localparam int unsigned EXIT_CYC_MAX = EXIT_HALF_MAX / HALF_PER_CLK;

    // =========================================================================
    // widths and values
    localparam int unsigned CFG_W = 16;
    localparam int unsigned ADDR_W = 24;
    localparam int unsigned FLT_W = 4;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned EXIT_W = 3;
    localparam logic [CFG_W-1:0] CFG_PULLED = 16'hffff;
    localparam logic [ADDR_W-1:0] RESTART_ADDR = 24'h000000;
    localparam logic [7:0] RESTART_SEG = 8'h00;
    localparam logic [15:0] FLASH_EARLY_WORD = 16'hffff;
    localparam logic [15:0] FLASH_LATE_WORD = 16'h009b;
    localparam logic [FLT_W-1:0] FLT_ZERO = 4'h0;
    localparam logic [FLT_W-1:0] FLT_LIMIT = FLT_W'(SPIKE_CYC);

    // =========================================================================
    // types
    typedef enum logic [1:0] {
        ARSEQ_RUN,
        ARSEQ_HOLD,
        ARSEQ_FLASH,
        ARSEQ_EXIT
    } arseq_state_e;

    typedef struct packed {
        logic bus_abort;
        logic hold_cancel;
        logic io_tristate;
        logic cfg_pullup;
    } arseq_force_s;

    typedef struct packed {
        logic ale;
        logic read_strobe_n;
        logic write_strobe_n;
    } arseq_strobe_s;

endpackage

// ==== verilog/arseq_filter.sv ====
// spike filter on the reset input, assert counted and registered on core_clk, and synchronised release
`timescale 1ns/1ps
`default_nettype none
module arseq_filter
    import arseq_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_in_n,
    input wire logic reset_mode_select,
    output logic async_hit,
    output logic released
);
    logic [FLT_W-1:0] low_cnt_ff;
    logic [FLT_W-1:0] nxt_low_cnt;
    logic async_req;

    // =========================================================================
    // a low shorter than the limit never reaches the counter end
    always_comb begin
        if (reset_in_n) begin
            nxt_low_cnt = FLT_ZERO;
        end else if (low_cnt_ff == FLT_LIMIT) begin
            nxt_low_cnt = low_cnt_ff;
        end else begin
            nxt_low_cnt = low_cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        low_cnt_ff <= nxt_low_cnt;
    end

    // mode pin low joins an already filtered low at any moment
    assign async_req = (low_cnt_ff == FLT_LIMIT) && !reset_mode_select;

    // =========================================================================
    // hit is a level; release only after the input has stayed high a clock
    always_ff @(posedge core_clk) begin
        async_hit <= async_req;
        released <= reset_in_n && (low_cnt_ff == FLT_ZERO);
    end
endmodule
`default_nettype wire

// ==== verilog/arseq_top.sv ====
// asynchronous reset entry and exit sequencer
// Summary of operation
// - with bidir enabled and mode pin low, soft and watchdog resets never drive input
// - lows shorter than 50 ns on the reset input are ignored as spikes
// - reset input low with mode pin low enters asynchronous reset, even mid-reset
// - on entry drive reset out low, cancel holds, abort bus, tristate, pull config high
// - detection is counted and registered on core_clk, so it needs a running clock
// - internal boot holds internal reset until flash init done, at most 1 ms
// - external boot releases after filter delay plus 3 to 8 half periods
// - flash reads during init return ffff then 009b
// - reset input high restarts device, after flash init on internal boot
// - on exit capture config port and drive strobes inactive
// - fetch starts at address zero in code segment zero
// - one half period unit is half a cpu clock
// - reset input low with mode pin high goes to warm reset path
`timescale 1ns/1ps
`default_nettype none
module arseq_top
    import arseq_pkg::*;
#(
    parameter int unsigned FLASH_INIT_CYC = FLASH_INIT_CYC_DEF,
    parameter logic [EXIT_W-1:0] EXIT_CYC = EXIT_W'(EXIT_CYC_MAX)
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic reset_in_n,
    input wire logic reset_mode_select,
    input wire logic external_boot_n,
    input wire logic bidir_reset_enable,
    input wire logic software_initiated,
    input wire logic watchdog_timer,
    input wire logic flash_init_done,
    input wire logic [CFG_W-1:0] config_port,
    output logic reset_out_n,
    output logic reset_in_drive_low,
    output logic reset_in_drive_oe,
    output logic internal_reset,
    output logic warm_reset_req,
    output arseq_force_s force_ff,
    output logic [CFG_W-1:0] config_pull_value,
    output logic [CFG_W-1:0] system_config_reg,
    output arseq_strobe_s strobe_ff,
    output logic [ADDR_W-1:0] fetch_addr,
    output logic [7:0] code_segment,
    output logic flash_busy,
    output logic [15:0] flash_read_word
);
    arseq_state_e state_ff;
    arseq_state_e nxt_state;
    logic async_hit;
    logic released;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic flash_late_ff;
    logic [CNT_W-1:0] flash_half;
    logic boot_internal;
    logic drive_req;
    logic exit_done;
    logic flash_done;

    assign boot_internal = external_boot_n;
    assign flash_half = CNT_W'(FLASH_INIT_CYC / 2);
    // the first exit cycle counts as zero, so the phase lasts exactly EXIT_CYC clocks
    assign exit_done = (cnt_ff >= CNT_W'(EXIT_CYC) - 16'h0001);
    // a timeout bounds the wait should the flash never report back
    assign flash_done = flash_init_done || (cnt_ff >= CNT_W'(FLASH_INIT_CYC));

    // =========================================================================
    // filter and release synchroniser
    arseq_filter u_filter (
        .core_clk(core_clk),
        .reset_in_n(reset_in_n),
        .reset_mode_select(reset_mode_select),
        .async_hit(async_hit),
        .released(released)
    );

    // =========================================================================
    // sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ARSEQ_RUN: begin
                if (async_hit) begin
                    nxt_state = ARSEQ_HOLD;
                end
            end
            ARSEQ_HOLD: begin
                if (!async_hit && released) begin
                    nxt_state = boot_internal ? ARSEQ_FLASH : ARSEQ_EXIT;
                end
            end
            ARSEQ_FLASH: begin
                if (async_hit) begin
                    nxt_state = ARSEQ_HOLD;
                end else if (flash_done) begin
                    nxt_state = ARSEQ_RUN;
                end
            end
            ARSEQ_EXIT: begin
                if (async_hit) begin
                    nxt_state = ARSEQ_HOLD;
                end else if (exit_done) begin
                    nxt_state = ARSEQ_RUN;
                end
            end
            default: begin
                nxt_state = ARSEQ_HOLD;
            end
        endcase
    end

    always_comb begin
        if (nxt_state != state_ff || state_ff == ARSEQ_RUN || state_ff == ARSEQ_HOLD) begin
            nxt_cnt = '0;
        end else if (cnt_ff == '1) begin
            nxt_cnt = cnt_ff;
        end else begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
    end

    // srst puts the block in hold, the same as a power-on reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_ff <= ARSEQ_HOLD;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // =========================================================================
    // reset output and forced default state
    // async_hit forces outputs one clock after it is seen, on the same edge that moves the state to hold
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reset_out_n <= 1'b0;
            internal_reset <= 1'b1;
            force_ff <= '1;
            config_pull_value <= CFG_PULLED;
        end else begin
            reset_out_n <= !(async_hit || nxt_state != ARSEQ_RUN);
            internal_reset <= async_hit || nxt_state != ARSEQ_RUN;
            force_ff.bus_abort <= async_hit || nxt_state == ARSEQ_HOLD;
            force_ff.hold_cancel <= async_hit || nxt_state == ARSEQ_HOLD;
            force_ff.io_tristate <= async_hit || nxt_state != ARSEQ_RUN;
            force_ff.cfg_pullup <= async_hit || nxt_state == ARSEQ_HOLD;
            config_pull_value <= CFG_PULLED;
        end
    end

    // =========================================================================
    // warm reset hand-off and bidirectional drive of the reset input
    // while the pin is driven low, the filter sees it; mode pin low blocks the drive
    assign drive_req = bidir_reset_enable && reset_mode_select
        && (software_initiated || watchdog_timer);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            reset_in_drive_low <= 1'b0;
            reset_in_drive_oe <= 1'b0;
            warm_reset_req <= 1'b0;
        end else begin
            reset_in_drive_low <= 1'b0;
            reset_in_drive_oe <= drive_req;
            warm_reset_req <= !reset_in_n && reset_mode_select
                && state_ff == ARSEQ_RUN && !async_hit;
        end
    end

    // =========================================================================
    // exit: latch config, idle strobes, restart address
    always_ff @(posedge core_clk) begin
        if (srst) begin
            system_config_reg <= '0;
            // ale idles low, read and write strobes idle high
            strobe_ff.ale <= 1'b0;
            strobe_ff.read_strobe_n <= 1'b1;
            strobe_ff.write_strobe_n <= 1'b1;
            fetch_addr <= RESTART_ADDR;
            code_segment <= RESTART_SEG;
        end else begin
            if (state_ff == ARSEQ_HOLD && nxt_state != ARSEQ_HOLD) begin
                system_config_reg <= config_port;
            end
            if (state_ff != ARSEQ_RUN) begin
                strobe_ff.ale <= 1'b0;
                strobe_ff.read_strobe_n <= 1'b1;
                strobe_ff.write_strobe_n <= 1'b1;
                fetch_addr <= RESTART_ADDR;
                code_segment <= RESTART_SEG;
            end
        end
    end

    // =========================================================================
    // flash answer while it initialises
    // early and late phases are split at half the timeout; real timing is flash-internal
    always_ff @(posedge core_clk) begin
        if (srst) begin
            flash_late_ff <= 1'b0;
            flash_busy <= 1'b1;
            flash_read_word <= FLASH_EARLY_WORD;
        end else begin
            if (state_ff == ARSEQ_HOLD) begin
                flash_late_ff <= 1'b0;
            end else if (cnt_ff >= flash_half) begin
                flash_late_ff <= 1'b1;
            end
            flash_busy <= (nxt_state == ARSEQ_HOLD) || (nxt_state == ARSEQ_FLASH)
                || (!boot_internal && !flash_init_done && nxt_state != ARSEQ_RUN);
            flash_read_word <= flash_late_ff ? FLASH_LATE_WORD : FLASH_EARLY_WORD;
        end
    end
endmodule
`default_nettype wire

// ==== tb/arseq_top_assertions.sv ====
// concurrent checks on the ports of the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module arseq_chk
    import arseq_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic reset_in_n,
    input wire logic reset_mode_select,
    input wire logic bidir_reset_enable,
    input wire logic software_initiated,
    input wire logic watchdog_timer,
    input wire logic [CFG_W-1:0] config_port,
    input wire logic reset_out_n,
    input wire logic reset_in_drive_low,
    input wire logic reset_in_drive_oe,
    input wire logic internal_reset,
    input wire arseq_force_s force_ff,
    input wire logic [CFG_W-1:0] config_pull_value,
    input wire logic [CFG_W-1:0] system_config_reg,
    input wire arseq_strobe_s strobe_ff,
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic [7:0] code_segment
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // ========================================================================
    // sequences
    sequence s_spike;
        reset_out_n && $fell(reset_in_n) ##1 reset_in_n [*3];
    endsequence
    sequence s_async_low;
        (!reset_in_n && !reset_mode_select) [*4];
    endsequence
    // oe is registered, so the cause is looked at one cycle back
    sequence s_blocked;
        (!reset_mode_select || !bidir_reset_enable) ##1 1'b1;
    endsequence
    // ========================================================================
    // assertions
    a_spike_ignored: assert property (s_spike |-> reset_out_n)
        else $error("single cycle low on reset input caused a reset");
    a_async_entry: assert property (s_async_low |-> ##[1:3] !reset_out_n)
        else $error("reset output not low after held reset input");
    a_force_state: assert property ($fell(reset_out_n) |->
        force_ff == 4'hf && config_pull_value == CFG_PULLED)
        else $error("default state not forced on reset entry");
    a_strobe_idle: assert property (internal_reset && $past(internal_reset) |->
        strobe_ff == 3'h3)
        else $error("strobes active during reset");
    a_restart_addr: assert property ($fell(internal_reset) |->
        fetch_addr == RESTART_ADDR && code_segment == RESTART_SEG)
        else $error("restart address wrong on reset exit");
    a_config_latch: assert property ($fell(internal_reset) |->
        system_config_reg == config_port)
        else $error("config not captured on reset exit");
    a_bidir_inhibit: assert property (s_blocked |->
        !reset_in_drive_oe && !reset_in_drive_low)
        else $error("reset pin driven while bidir reset is inhibited");
    a_bidir_drive: assert property (bidir_reset_enable && reset_mode_select &&
        (software_initiated || watchdog_timer) && !internal_reset |=>
        reset_in_drive_oe)
        else $error("reset pin not driven for soft or watchdog reset");
endmodule

bind arseq_top arseq_chk chk_u (
    .core_clk(core_clk), .srst(srst), .reset_in_n(reset_in_n),
    .reset_mode_select(reset_mode_select), .bidir_reset_enable(bidir_reset_enable),
    .software_initiated(software_initiated), .watchdog_timer(watchdog_timer),
    .config_port(config_port), .reset_out_n(reset_out_n),
    .reset_in_drive_low(reset_in_drive_low), .reset_in_drive_oe(reset_in_drive_oe),
    .internal_reset(internal_reset), .force_ff(force_ff),
    .config_pull_value(config_pull_value), .system_config_reg(system_config_reg),
    .strobe_ff(strobe_ff), .fetch_addr(fetch_addr), .code_segment(code_segment)
);
`default_nettype wire

// ==== tb/arseq_supervisor.sv ====
// behavioural board supervisor driving the reset and mode pins
`timescale 1ns/1ps
`default_nettype none
module arseq_supervisor
    import arseq_pkg::*;
#(
    parameter int unsigned POR_CYC = 25000
)
(
    input wire logic core_clk,
    output logic rst_drive_n,
    output logic mode_sel,
    output logic [CFG_W-1:0] cfg_pins
);
    // powered up with both pins low and the config pins already settled
    initial begin
        rst_drive_n = 1'b0;
        mode_sel = 1'b0;
        cfg_pins = 16'h5a3c;
    end
    // 1 ms of supply settling; oscillator start is assumed already done
    task automatic power_up();
        repeat (POR_CYC) @(posedge core_clk);
        rst_drive_n <= 1'b1;
    endtask
    // n of 13 or more exceeds 500 ns and the 4 half period minimum
    task automatic pulse(input int n, input logic mode);
        @(posedge core_clk);
        mode_sel <= mode;
        rst_drive_n <= 1'b0;
        repeat (n) @(posedge core_clk);
        rst_drive_n <= 1'b1;
    endtask
    task automatic set_mode(input logic m);
        @(posedge core_clk);
        mode_sel <= m;
    endtask
endmodule
`default_nettype wire

// ==== tb/arseq_top_tb_top.sv ====
// self-checking bench for the asynchronous reset sequencer
`timescale 1ns/1ps
`default_nettype none
module arseq_top_tb_top
    import arseq_pkg::*;
;
    localparam logic [EXIT_W-1:0] EXIT_SIM = 3'h3;
    localparam int unsigned FLASH_SIM = 40;
    logic core_clk, srst, ext_boot_n, bidir_en, sw_rst, wdt_rst, flash_done;
    logic sup_rst_n, mode_sel, out_n, oe, drv, int_rst, warm, busy;
    logic [CFG_W-1:0] cfg_pins, pull_val, sys_cfg;
    arseq_force_s frc;
    arseq_strobe_s strb;
    logic [ADDR_W-1:0] faddr;
    logic [7:0] cseg;
    logic [15:0] fword;
    wire logic pin_rst_n;
    int errors;
    int tests_run;
    int n;
    // open-drain pin: either party may pull it low
    assign pin_rst_n = sup_rst_n & (oe ? drv : 1'b1);
    arseq_supervisor sup_u (.core_clk(core_clk), .rst_drive_n(sup_rst_n),
        .mode_sel(mode_sel), .cfg_pins(cfg_pins));
    arseq_top #(.FLASH_INIT_CYC(FLASH_SIM), .EXIT_CYC(EXIT_SIM)) dut_u (
        .core_clk(core_clk), .srst(srst), .reset_in_n(pin_rst_n),
        .reset_mode_select(mode_sel), .external_boot_n(ext_boot_n),
        .bidir_reset_enable(bidir_en), .software_initiated(sw_rst),
        .watchdog_timer(wdt_rst), .flash_init_done(flash_done), .config_port(cfg_pins),
        .reset_out_n(out_n), .reset_in_drive_low(drv), .reset_in_drive_oe(oe),
        .internal_reset(int_rst), .warm_reset_req(warm), .force_ff(frc),
        .config_pull_value(pull_val), .system_config_reg(sys_cfg), .strobe_ff(strb),
        .fetch_addr(faddr), .code_segment(cseg), .flash_busy(busy),
        .flash_read_word(fword));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // ========================================================================
    // shared tasks
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // settle after the edge so the design's updates have landed
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_lvl(input string what, ref logic sig, input logic val);
        for (n = 0; n < 200 && sig !== val; n++) begin
            tick(1);
        end
        chk(what, val, sig);
        if (sig !== val) begin
            complete_run();
        end
    endtask
    // ========================================================================
    // scenarios
    task automatic sc_boot_external();
        sup_u.power_up();
        wait_lvl("internal reset", int_rst, 1'b0);
        chk("exit delay ok", 24'h1, n > EXIT_SIM && n <= EXIT_SIM + 4);
        chk("config", 24'h5a3c, sys_cfg);
        chk("strobes", 3'h3, strb);
        chk("fetch", 24'h0, {faddr});
        chk("segment", 8'h00, cseg);
        wait_lvl("reset out", out_n, 1'b1);
    endtask
    task automatic sc_spike();
        sup_u.pulse(1, 1'b0);
        tick(6);
        chk("reset out", 1'b1, out_n);
    endtask
    task automatic sc_bidir();
        for (int i = 0; i < 8; i++) begin
            sup_u.set_mode(i[1]);
            bidir_en <= i[0];
            sw_rst <= !i[2];
            wdt_rst <= i[2];
            tick(1);
            chk("pin drive", i[0] && i[1], oe);
            @(posedge core_clk);
            sw_rst <= 1'b0;
            wdt_rst <= 1'b0;
            tick(6);
        end
        sup_u.set_mode(1'b0);
        bidir_en <= 1'b0;
        tick(4);
    endtask
    task automatic sc_warm_to_async();
        fork
            sup_u.pulse(30, 1'b1);
            begin
                tick(8);
                chk("warm request", 1'b1, warm);
                chk("reset out", 1'b1, out_n);
                sup_u.set_mode(1'b0);
                tick(6);
                chk("reset out", 1'b0, out_n);
                chk("forced", 4'hf, frc);
                chk("pull value", CFG_PULLED, pull_val);
                chk("drive value", 1'b0, drv);
            end
        join
        wait_lvl("reset out", out_n, 1'b1);
    endtask
    task automatic sc_flash_boot();
        @(posedge core_clk);
        ext_boot_n <= 1'b1;
        flash_done <= 1'b0;
        sup_u.pulse(20, 1'b0);
        tick(10);
        chk("flash early", FLASH_EARLY_WORD, fword);
        chk("flash busy", 1'b1, busy);
        tick(20);
        chk("flash late", FLASH_LATE_WORD, fword);
        chk("internal reset", 1'b1, int_rst);
        @(posedge core_clk);
        flash_done <= 1'b1;
        wait_lvl("internal reset", int_rst, 1'b0);
        chk("flash busy", 1'b0, busy);
    endtask
    // ========================================================================
    // main sequence
    initial begin
        errors = 0;
        tests_run = 0;
        {srst, ext_boot_n, bidir_en, sw_rst, wdt_rst, flash_done} = 6'h20;
        tick(8);
        chk("reset out", 1'b0, out_n);
        chk("forced", 4'hf, frc);
        @(posedge core_clk);
        srst <= 1'b0;
        sc_boot_external();
        sc_spike();
        sc_bidir();
        sc_warm_to_async();
        sc_flash_boot();
        complete_run();
    end
endmodule
`default_nettype wire
